// *** src/psrc_ctrl.sv ***
// Switch pulse timing, current-limit jitter and protection sequencing of a flyback switcher.
// Assumes comparator and supply indications arrive asynchronously as levels on pins.
// Functional notes
// R1: Each switch turn-on is followed by a 300 ns blanking interval before current sense counts.
// R2: During blanking the current comparator is ignored and only a fault stop ends the on pulse.
// R3: The next turn-on occurs at a detected valley only if the dead time is under the window.
// R4: The current-limit level steps every 2 switching cycles and repeats every 12 cycles.
// R5: The jitter levels span from lowest to highest within plus or minus 3 percent of the mean.
// R6: The line-compensation switch is closed only while the primary switch is on.
// R7: Auto-recovery keeps switching stopped and restarts when the supply returns to start after falling to its minimum.
// R8: Supply overvoltage stops the drive at once and enters auto-recovery.
// R9: Three consecutive cycles of feedback overvoltage enter auto-recovery.
// R10: Three consecutive pulses above the saturation limit shut down into auto-recovery.
// R11: Over-temperature shuts down immediately into auto-recovery.
// R12: After thermal shutdown no pulse is issued until the temperature drops by the hysteresis.
// R13: The bus is sampled every cycle and three consecutive low samples shut down.
// R14: Each restart emits one probe pulse and continues only if the bus sample is high.
// R15: Each on pulse ends when sensed current reaches the current-limit reference.
// R16: Feedback is sampled at 55 or 60 percent of the secondary conduction time.
// R17: Each fault counter clears in a cycle without its fault and on auto-recovery entry.
`timescale 1ns/1ps
module psrc_ctrl #(
  parameter int unsigned BLANK_CYCLES  = psrc_pkg::BLANK_CYC,
  parameter int unsigned VALLEY_CYCLES = psrc_pkg::VALLEY_WIN_CYC,
  parameter int unsigned MAXOFF_CYCLES = psrc_pkg::MAX_OFF_CYC
) (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  input  wire psrc_pkg::psrc_sense_t        sense_in,
  input  wire psrc_pkg::psrc_supply_t       supply_in,
  output logic                              gate_drive,
  output logic                              line_comp_sw,
  output logic                              fb_sample,
  output logic [psrc_pkg::LVL_W-1:0]        jitter_level,
  output logic                              auto_recovery,
  output psrc_pkg::psrc_fault_t             fault_flags
);

  initial begin
    if (BLANK_CYCLES < 1 || BLANK_CYCLES >= (1 << psrc_pkg::TMR_W))
      $error("psrc_ctrl: BLANK_CYCLES out of range.");
    if (VALLEY_CYCLES < 1 || VALLEY_CYCLES >= MAXOFF_CYCLES)
      $error("psrc_ctrl: VALLEY_CYCLES must be below MAXOFF_CYCLES.");
    if (MAXOFF_CYCLES >= (1 << psrc_pkg::TMR_W))
      $error("psrc_ctrl: MAXOFF_CYCLES exceeds timer width.");
  end

  localparam logic [psrc_pkg::TMR_W-1:0] BLANK_T  = psrc_pkg::TMR_W'(BLANK_CYCLES);
  localparam logic [psrc_pkg::TMR_W-1:0] VALLEY_T = psrc_pkg::TMR_W'(VALLEY_CYCLES);
  localparam logic [psrc_pkg::TMR_W-1:0] MAXOFF_T = psrc_pkg::TMR_W'(MAXOFF_CYCLES);

  localparam int unsigned SW = $bits(psrc_pkg::psrc_sense_t) + $bits(psrc_pkg::psrc_supply_t);

  psrc_pkg::psrc_sense_t  sense_s;
  psrc_pkg::psrc_supply_t supply_s;

  psrc_sync #(.WIDTH(SW)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({sense_in, supply_in}),
    .sync_out ({sense_s, supply_s})
  );

  psrc_pkg::psrc_state_t          state_q;
  psrc_pkg::psrc_state_t          state_d;
  logic [psrc_pkg::TMR_W-1:0]     tmr_q;
  logic [psrc_pkg::TMR_W-1:0]     samp_pt_q;
  logic [psrc_pkg::FCNT_W-1:0]    ovp_cnt_q;
  logic [psrc_pkg::FCNT_W-1:0]    sat_cnt_q;
  logic [psrc_pkg::FCNT_W-1:0]    bus_cnt_q;
  logic [psrc_pkg::JIT_W-1:0]     jit_cyc_q;
  logic                           ovp_hit;
  logic                           thermal_lock_q;
  logic                           vcc_dropped_q;
  logic                           cycle_end;
  logic                           blank_done;
  logic                           trip_now;
  logic                           fault_stop;
  logic                           counted_trip;

  function automatic logic cnt_hit(input logic [psrc_pkg::FCNT_W-1:0] cnt, input logic ev);
    cnt_hit = ev && (cnt == psrc_pkg::FCNT_MAX - 2'h1);
  endfunction : cnt_hit

  function automatic logic [psrc_pkg::FCNT_W-1:0] cnt_next(
      input logic [psrc_pkg::FCNT_W-1:0] cnt, input logic ev);
    cnt_next = ev ? cnt + 2'h1 : psrc_pkg::FCNT_ZERO;
  endfunction : cnt_next

  assign blank_done   = (tmr_q >= BLANK_T); // R1
  assign trip_now     = (state_q == psrc_pkg::PSRC_ST_ON) && blank_done
                        && (sense_s.cs_trip || sense_s.cs_sat); // R2 R15
  assign cycle_end    = trip_now;
  assign counted_trip = cycle_end && !(state_q == psrc_pkg::PSRC_ST_PROBE);
  assign fault_stop   = supply_s.vcc_ovp || supply_s.otp_hot // R8 R11
                        || ovp_hit // R9
                        || cnt_hit(sat_cnt_q, sense_s.cs_sat) && cycle_end // R10
                        || cnt_hit(bus_cnt_q, sense_s.bus_low) && cycle_end; // R13

  always_comb begin
    state_d = state_q;
    case (state_q)
      psrc_pkg::PSRC_ST_OFF: begin
        if (supply_s.vcc_start && !thermal_lock_q) state_d = psrc_pkg::PSRC_ST_ON;
      end
      psrc_pkg::PSRC_ST_ON: begin
        if (trip_now) state_d = psrc_pkg::PSRC_ST_DEMAG;
      end
      psrc_pkg::PSRC_ST_DEMAG: begin
        if (sense_s.demag_end) state_d = psrc_pkg::PSRC_ST_DEAD;
      end
      psrc_pkg::PSRC_ST_DEAD: begin
        if ((sense_s.valley && tmr_q < VALLEY_T) || tmr_q >= MAXOFF_T)
          state_d = psrc_pkg::PSRC_ST_ON; // R3
      end
      psrc_pkg::PSRC_ST_RECOVER: begin
        if (vcc_dropped_q && supply_s.vcc_start && !thermal_lock_q)
          state_d = psrc_pkg::PSRC_ST_PROBE; // R7 R12 R14
      end
      psrc_pkg::PSRC_ST_PROBE: begin
        if (blank_done && sense_s.cs_trip) state_d = psrc_pkg::PSRC_ST_PROBE_WAIT;
      end
      psrc_pkg::PSRC_ST_PROBE_WAIT: begin
        if (sense_s.demag_end)
          state_d = sense_s.bus_high ? psrc_pkg::PSRC_ST_DEAD
                                     : psrc_pkg::PSRC_ST_RECOVER; // R14
      end
      default: state_d = psrc_pkg::PSRC_ST_OFF;
    endcase
    if (fault_stop) state_d = psrc_pkg::PSRC_ST_RECOVER; // R8 R11
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) state_q <= psrc_pkg::PSRC_ST_OFF;
    else         state_q <= state_d;
  end

  // Phase timer restarts on each state change.
  always_ff @(posedge core_clk) begin
    if (sys_rst) tmr_q <= psrc_pkg::TMR_ZERO;
    else if (state_d != state_q) tmr_q <= psrc_pkg::TMR_ZERO;
    else if (tmr_q != {psrc_pkg::TMR_W{1'b1}}) tmr_q <= tmr_q + psrc_pkg::TMR_ONE;
  end

  // Secondary conduction length is learned each cycle to place the feedback sample point.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      samp_pt_q <= psrc_pkg::TMR_ZERO;
      fb_sample <= 1'b0;
    end else begin
      if (state_q == psrc_pkg::PSRC_ST_DEMAG && sense_s.demag_end) begin
        samp_pt_q <= psrc_pkg::TMR_W'((32'(tmr_q) * (sense_s.heavy_load
                     ? psrc_pkg::SAMPLE_PCT_HEAVY : psrc_pkg::SAMPLE_PCT_LIGHT))
                     / psrc_pkg::PCT_FULL); // R16
      end
      fb_sample <= (state_q == psrc_pkg::PSRC_ST_DEMAG) && (tmr_q == samp_pt_q); // R16
    end
  end

  // Overvoltage is judged at each feedback sample, so the third bad sample stops at once.
  assign ovp_hit = fb_sample && cnt_hit(ovp_cnt_q, sense_s.fb_ovp); // R9

  always_ff @(posedge core_clk) begin
    if (sys_rst || state_d == psrc_pkg::PSRC_ST_RECOVER)
      ovp_cnt_q <= psrc_pkg::FCNT_ZERO; // R17
    else if (fb_sample)
      ovp_cnt_q <= cnt_next(ovp_cnt_q, sense_s.fb_ovp); // R9 R17
  end

  // Consecutive-cycle fault counters.
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_d == psrc_pkg::PSRC_ST_RECOVER) begin
      sat_cnt_q <= psrc_pkg::FCNT_ZERO; // R17
      bus_cnt_q <= psrc_pkg::FCNT_ZERO; // R17
    end else if (counted_trip) begin
      sat_cnt_q <= cnt_next(sat_cnt_q, sense_s.cs_sat); // R10 R17
      bus_cnt_q <= cnt_next(bus_cnt_q, sense_s.bus_low); // R13 R17
    end
  end

  // Jitter sequence advances once per switching cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) jit_cyc_q <= psrc_pkg::JIT_ZERO;
    else if (cycle_end)
      jit_cyc_q <= (jit_cyc_q == psrc_pkg::JIT_LAST) ? psrc_pkg::JIT_ZERO
                                                     : jit_cyc_q + 4'h1; // R4
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) jitter_level <= psrc_pkg::JIT_LVL_LOW;
    else begin
      case (jit_cyc_q[psrc_pkg::JIT_W-1:1]) // R4
        3'h0:    jitter_level <= psrc_pkg::JIT_LVL_LOW; // R5
        3'h1:    jitter_level <= psrc_pkg::JIT_LVL_MID_LO;
        3'h2:    jitter_level <= psrc_pkg::JIT_LVL_MID_HI;
        3'h3:    jitter_level <= psrc_pkg::JIT_LVL_HIGH; // R5
        3'h4:    jitter_level <= psrc_pkg::JIT_LVL_MID_HI;
        default: jitter_level <= psrc_pkg::JIT_LVL_MID_LO;
      endcase
    end
  end

  // Thermal lock and supply-drop memory for the restart.
  always_ff @(posedge core_clk) begin
    if (sys_rst) thermal_lock_q <= 1'b0;
    else if (supply_s.otp_hot) thermal_lock_q <= 1'b1; // R11
    else if (supply_s.otp_cool) thermal_lock_q <= 1'b0; // R12
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || state_q != psrc_pkg::PSRC_ST_RECOVER) vcc_dropped_q <= 1'b0;
    else if (supply_s.vcc_min) vcc_dropped_q <= 1'b1; // R7
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gate_drive    <= 1'b0;
      line_comp_sw  <= 1'b0;
      auto_recovery <= 1'b0;
    end else begin
      gate_drive    <= (state_d == psrc_pkg::PSRC_ST_ON || state_d == psrc_pkg::PSRC_ST_PROBE);
      line_comp_sw  <= (state_d == psrc_pkg::PSRC_ST_ON
                        || state_d == psrc_pkg::PSRC_ST_PROBE); // R6
      auto_recovery <= (state_d == psrc_pkg::PSRC_ST_RECOVER);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) fault_flags <= '0;
    else if (fault_stop) begin
      fault_flags.vcc_ovp  <= supply_s.vcc_ovp;
      fault_flags.thermal  <= supply_s.otp_hot;
      fault_flags.overvoltage_guard      <= ovp_hit;
      fault_flags.sat      <= cnt_hit(sat_cnt_q, sense_s.cs_sat) && cycle_end;
      fault_flags.bus_open <= cnt_hit(bus_cnt_q, sense_s.bus_low) && cycle_end;
    end else if (state_q == psrc_pkg::PSRC_ST_DEAD) fault_flags <= '0;
  end

  blank_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    state_q == psrc_pkg::PSRC_ST_ON && !blank_done && !fault_stop
    |=> state_q == psrc_pkg::PSRC_ST_ON)
    else $error("On pulse ended during blanking.");

  vcc_ovp_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
    supply_s.vcc_ovp |=> !gate_drive)
    else $error("Drive not stopped on supply overvoltage.");

  thermal_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
    supply_s.otp_hot |=> auto_recovery || state_q == psrc_pkg::PSRC_ST_OFF)
    else $error("Thermal fault did not stop switching.");

  thermal_lock_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
    thermal_lock_q && state_q == psrc_pkg::PSRC_ST_RECOVER |=> !gate_drive)
    else $error("Pulse issued under thermal lock.");

  lc_switch_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
    line_comp_sw == gate_drive)
    else $error("Line compensation switch out of step with drive.");

  recover_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
    auto_recovery |-> !gate_drive)
    else $error("Switching during auto-recovery.");

  sat_trip_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
    sat_cnt_q == 2'h2 && counted_trip && sense_s.cs_sat |=> state_q == psrc_pkg::PSRC_ST_RECOVER)
    else $error("Third saturation pulse did not shut down.");

  bus_trip_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R13
    bus_cnt_q == 2'h2 && counted_trip && sense_s.bus_low |=> auto_recovery)
    else $error("Third low bus sample did not shut down.");

  jitter_wrap_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    cycle_end && jit_cyc_q == psrc_pkg::JIT_LAST |=> jit_cyc_q == psrc_pkg::JIT_ZERO)
    else $error("Jitter sequence did not wrap at 12 cycles.");

  jitter_pair_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    cycle_end && !jit_cyc_q[0] |=> ##1 $stable(jitter_level))
    else $error("Limit level changed inside a step pair.");

  ovp_trip_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
    ovp_cnt_q == 2'h2 && fb_sample && sense_s.fb_ovp |=> auto_recovery)
    else $error("Third overvoltage sample did not shut down.");

  cs_end_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R15
    trip_now |=> !gate_drive)
    else $error("On pulse did not end at the current limit.");

  valley_on_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
    state_q == psrc_pkg::PSRC_ST_DEAD && sense_s.valley && tmr_q < VALLEY_T && !fault_stop
    |=> gate_drive)
    else $error("Valley inside the window did not turn on.");

  late_valley_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
    state_q == psrc_pkg::PSRC_ST_DEAD && tmr_q >= VALLEY_T && tmr_q < MAXOFF_T |=> !gate_drive)
    else $error("Turn-on after the valley window closed.");

  fcnt_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R17
    auto_recovery |-> ovp_cnt_q == psrc_pkg::FCNT_ZERO && sat_cnt_q == psrc_pkg::FCNT_ZERO
                      && bus_cnt_q == psrc_pkg::FCNT_ZERO)
    else $error("Fault counter not cleared in auto-recovery.");

  probe_fail_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R14
    state_q == psrc_pkg::PSRC_ST_PROBE_WAIT && sense_s.demag_end && !sense_s.bus_high
    |=> auto_recovery)
    else $error("Failed probe did not return to auto-recovery.");

  probe_pass_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R14
    state_q == psrc_pkg::PSRC_ST_PROBE_WAIT && sense_s.demag_end && sense_s.bus_high
    && !fault_stop |=> state_q == psrc_pkg::PSRC_ST_DEAD)
    else $error("Passed probe did not resume switching.");

endmodule : psrc_ctrl

// *** src/psrc_pkg.sv ***
// Shared constants and carrier types for the flyback switch pulse and fault controller.
// Assumes a single 10 MHz core clock; analog comparators are sampled outside this package.
package psrc_pkg;

  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned BLANK_NS         = 300;
  localparam int unsigned BLANK_CYC        = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned VALLEY_WIN_NS    = 3000;
  localparam int unsigned VALLEY_WIN_CYC   = (VALLEY_WIN_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned MAX_OFF_NS       = 100_000;
  localparam int unsigned MAX_OFF_CYC      = (MAX_OFF_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned FAULT_CNT_LIMIT  = 3;
  localparam int unsigned JIT_STEP_CYCLES  = 2;
  localparam int unsigned JIT_PERIOD       = 12;
  localparam int unsigned SAMPLE_PCT_LIGHT = 55;
  localparam int unsigned SAMPLE_PCT_HEAVY = 60;
  localparam int unsigned PCT_FULL         = 100;

  localparam int unsigned TMR_W   = 12;
  localparam int unsigned FCNT_W  = 2;
  localparam int unsigned JIT_W   = 4;
  localparam int unsigned LVL_W   = 3;

  localparam logic [FCNT_W-1:0] FCNT_MAX  = 2'h3;
  localparam logic [FCNT_W-1:0] FCNT_ZERO = 2'h0;
  localparam logic [JIT_W-1:0]  JIT_ZERO  = 4'h0;
  localparam logic [JIT_W-1:0]  JIT_LAST  = 4'hb;
  localparam logic [TMR_W-1:0]  TMR_ZERO  = 12'h000;
  localparam logic [TMR_W-1:0]  TMR_ONE   = 12'h001;

  // Jitter level 0 is the lowest step (mean minus 3 percent), level 3 the highest.
  localparam logic [LVL_W-1:0] JIT_LVL_MID_LO = 3'h1;
  localparam logic [LVL_W-1:0] JIT_LVL_MID_HI = 3'h2;
  localparam logic [LVL_W-1:0] JIT_LVL_HIGH   = 3'h3;
  localparam logic [LVL_W-1:0] JIT_LVL_LOW    = 3'h0;

  typedef enum logic [2:0] {
    PSRC_ST_OFF,
    PSRC_ST_ON,
    PSRC_ST_DEMAG,
    PSRC_ST_DEAD,
    PSRC_ST_RECOVER,
    PSRC_ST_PROBE,
    PSRC_ST_PROBE_WAIT
  } psrc_state_t;

  // Comparator and supervisor indications from the power stage.
  typedef struct packed {
    logic cs_trip;
    logic cs_sat;
    logic demag_end;
    logic valley;
    logic fb_ovp;
    logic bus_low;
    logic bus_high;
    logic heavy_load;
  } psrc_sense_t;

  typedef struct packed {
    logic vcc_ovp;
    logic otp_hot;
    logic otp_cool;
    logic vcc_start;
    logic vcc_min;
  } psrc_supply_t;

  typedef struct packed {
    logic overvoltage_guard;
    logic sat;
    logic bus_open;
    logic vcc_ovp;
    logic thermal;
  } psrc_fault_t;

endpackage : psrc_pkg

// *** src/psrc_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous comparator levels.
// Assumes inputs are quasi-static relative to the 10 MHz core clock.
`timescale 1ns/1ps
module psrc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("psrc_sync: WIDTH must be at least 1.");
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : psrc_sync

// *** testbench/psrc_stage_model.sv ***
// Behavioural flyback power stage that returns comparator levels to the controller.
// Assumes the controller clock, with levels changing just after its rising edge.
`timescale 1ns/1ps
module psrc_stage_model (
  input  wire logic             core_clk,
  input  wire logic             gate_drive,
  input  wire logic [7:0]       on_cyc,
  input  wire logic [7:0]       vly_cyc,
  input  wire logic [2:0]       fault_sel,
  input  wire logic             bus_ok,
  output psrc_pkg::psrc_sense_t sense_out
);
  localparam logic [7:0] COND_CYC = 8'h08;
  logic [7:0] on_q;
  logic [7:0] off_q;
  initial begin
    on_q      = 8'h00;
    off_q     = 8'hff;
    sense_out = '0;
  end
  // The on and off counters saturate so long idle phases never wrap.
  always @(posedge core_clk) begin
    on_q                 <= gate_drive ? on_q + {7'h00, on_q != 8'hff} : 8'h00;
    off_q                <= gate_drive ? 8'h00 : off_q + {7'h00, off_q != 8'hff};
    sense_out.cs_trip    <= gate_drive && (on_q >= on_cyc);
    sense_out.cs_sat     <= gate_drive && fault_sel[1];
    sense_out.demag_end  <= !gate_drive && (off_q >= COND_CYC) && (off_q < COND_CYC + 8'h03);
    sense_out.valley     <= !gate_drive && (off_q >= COND_CYC + vly_cyc);
    sense_out.fb_ovp     <= fault_sel[0];
    sense_out.bus_low    <= fault_sel[2];
    sense_out.bus_high   <= bus_ok;
    sense_out.heavy_load <= 1'b0;
  end
endmodule : psrc_stage_model

// *** testbench/psr_switch_pulse_and_fault_control_tb.sv ***
// Self-checking bench for the switch pulse and fault controller.
// Assumes the stage model file and shortened valley and off-time windows.
`timescale 1ns/1ps
module psr_switch_pulse_and_fault_control_tb;
  localparam int LIMIT = 20000;
  logic                        core_clk;
  logic                        sys_rst;
  psrc_pkg::psrc_sense_t       sense;
  psrc_pkg::psrc_supply_t      supply;
  logic                        gate_drive;
  logic                        line_comp_sw;
  logic                        fb_sample;
  logic [psrc_pkg::LVL_W-1:0]  jitter_level;
  logic                        auto_recovery;
  psrc_pkg::psrc_fault_t       fault_flags;
  logic [7:0]                  on_cyc;
  logic [7:0]                  vly_cyc;
  logic [2:0]                  fault_sel;
  logic                        bus_ok;
  int                          fail_count = 0;
  int                          tests_run = 0;
  int                          cyc_n = 0;
  int                          hi_n = 0;
  int                          samp_n = 0;
  bit                          skip_w = 1'b0;
  bit                          cap_en = 1'b0;
  logic                        gate_p = 1'b0;
  logic [psrc_pkg::LVL_W-1:0]  lv_q [$];
  logic [psrc_pkg::LVL_W-1:0]  pat [12] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
                                             3'h3, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1};

  psrc_ctrl #(.VALLEY_CYCLES(5), .MAXOFF_CYCLES(20)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .sense_in(sense), .supply_in(supply),
    .gate_drive(gate_drive), .line_comp_sw(line_comp_sw), .fb_sample(fb_sample),
    .jitter_level(jitter_level), .auto_recovery(auto_recovery), .fault_flags(fault_flags));

  psrc_stage_model u_stage (
    .core_clk(core_clk), .gate_drive(gate_drive), .on_cyc(on_cyc), .vly_cyc(vly_cyc),
    .fault_sel(fault_sel), .bus_ok(bus_ok), .sense_out(sense));

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic note(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : note

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    note(got === exp, msg);
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int lo, input int hi, input string msg);
    note(got >= lo && got <= hi, $sformatf("%s (%0d)", msg, got));
  endtask : chk_cnt

  task automatic chk_flags(input psrc_pkg::psrc_fault_t got, input psrc_pkg::psrc_fault_t exp);
    note(got === exp, "fault cause");
  endtask : chk_flags

  task automatic cyc();
    @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wait_gate(input logic lvl, input int lim, output int n);
    n = 0;
    while (gate_drive !== lvl && n < lim) begin
      cyc();
      n++;
    end
  endtask : wait_gate

  // Counts gate rises for lim cycles, or until recovery is entered when asked.
  task automatic watch(input int lim, input bit to_rec, output int r);
    logic p;
    r = 0;
    for (int i = 0; i < lim && !(to_rec && auto_recovery === 1'b1); i++) begin
      p = gate_drive;
      cyc();
      if (p !== 1'b1 && gate_drive === 1'b1) r++;
    end
  endtask : watch

  task automatic restart(input logic good);
    int n;
    int r;
    @(posedge core_clk);
    supply.vcc_start <= 1'b0;
    supply.vcc_min   <= 1'b1;
    bus_ok           <= good;
    fault_sel        <= 3'h0;
    repeat (4) @(posedge core_clk);
    supply.vcc_min   <= 1'b0;
    supply.vcc_start <= 1'b1;
    wait_gate(1'b1, 30, n);
    chk_bit(gate_drive, 1'b1, "no probe pulse");
    watch(80, 1'b0, r);
    chk_cnt(r, good ? 1 : 0, good ? 80 : 0, "pulses after probe");
    chk_bit(auto_recovery, !good, "recovery state after probe");
  endtask : restart

  always @(negedge core_clk) begin
    if (!sys_rst) begin
      chk_bit(line_comp_sw, gate_drive, "line comp switch");
      if (fb_sample === 1'b1) begin
        samp_n++;
        chk_bit(gate_drive, 1'b0, "sample in on time");
      end
      if (gate_drive === 1'b1) begin
        hi_n++;
        if (gate_p !== 1'b1 && cap_en) lv_q.push_back(jitter_level);
      end else if (hi_n > 0) begin
        if (!skip_w) chk_cnt(hi_n, int'(psrc_pkg::BLANK_CYC), 255, "short pulse");
        hi_n = 0;
      end
      gate_p = gate_drive;
    end
  end

  always @(posedge core_clk) begin
    cyc_n++;
    if (cyc_n == LIMIT) begin
      note(1'b0, "timeout");
      test_done();
    end
  end

  initial begin
    int n;
    int r;
    bit ok;
    bit m;
    sys_rst   = 1'b1;
    supply    = '0;
    on_cyc    = 8'h00;
    vly_cyc   = 8'h01;
    fault_sel = 3'h0;
    bus_ok    = 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc();
    chk_bit(gate_drive, 1'b0, "gate after reset");
    chk_bit(auto_recovery, 1'b0, "recovery after reset");
    chk_flags(fault_flags, '0);
    @(posedge core_clk);
    supply.vcc_start <= 1'b1;
    cap_en           <= 1'b1;
    for (n = 0; n < 1000 && lv_q.size() < 24; n++) begin
      cyc();
    end
    cap_en <= 1'b0;
    chk_cnt(samp_n, 23, 23, "one sample strobe per cycle");
    ok = 1'b0;
    for (int o = 0; o < 12; o++) begin
      m = (lv_q.size() >= 24);
      for (int i = 0; i < 24 && m; i++) begin
        m = (lv_q[i] === pat[(i + o) % 12]);
      end
      ok |= m;
    end
    chk_bit(ok, 1'b1, "limit step sequence");
    wait_gate(1'b0, 60, n);
    wait_gate(1'b1, 60, n);
    chk_cnt(n, 1, 19, "prompt valley turn-on");
    @(posedge core_clk);
    vly_cyc <= 8'h1e;
    wait_gate(1'b0, 60, n);
    wait_gate(1'b1, 80, n);
    chk_cnt(n, 20, 34, "forced turn-on");
    @(posedge core_clk);
    vly_cyc <= 8'h01;
    on_cyc  <= 8'h08;
    for (int k = 0; k < 3; k++) begin
      wait_gate(1'b0, 80, n);
      wait_gate(1'b1, 80, n);
      @(posedge core_clk);
      fault_sel <= 3'(1 << k);
      watch(300, 1'b1, r);
      chk_cnt(r + 1, 3, 3, "pulses before shutdown");
      chk_bit(gate_drive, 1'b0, "gate in recovery");
      chk_flags(fault_flags, psrc_pkg::psrc_fault_t'(5'h10 >> k));
      watch(30, 1'b0, r);
      chk_cnt(r, 0, 0, "switching before restart");
      restart(1'b0);
      restart(1'b1);
    end
    skip_w = 1'b1;
    for (int j = 0; j < 2; j++) begin
      wait_gate(1'b0, 80, n);
      wait_gate(1'b1, 80, n);
      @(posedge core_clk);
      supply.vcc_ovp <= (j == 0);
      supply.otp_hot <= (j == 1);
      wait_gate(1'b0, 10, n);
      chk_cnt(n, 1, 3, "drive not stopped at once");
      cyc();
      chk_bit(auto_recovery, 1'b1, "no recovery on supply fault");
      chk_flags(fault_flags, psrc_pkg::psrc_fault_t'(5'h02 >> j));
      @(posedge core_clk);
      supply.vcc_ovp <= 1'b0;
      supply.otp_hot <= 1'b0;
      if (j == 1) begin
        supply.vcc_start <= 1'b0;
        supply.vcc_min   <= 1'b1;
        repeat (4) @(posedge core_clk);
        supply.vcc_min   <= 1'b0;
        supply.vcc_start <= 1'b1;
        watch(40, 1'b0, r);
        chk_cnt(r, 0, 0, "pulse while too hot");
        @(posedge core_clk);
        supply.otp_cool <= 1'b1;
      end
      restart(1'b1);
    end
    test_done();
  end
endmodule : psr_switch_pulse_and_fault_control_tb
